//--- include/fesr_cfg.svh
`ifndef FESR_CFG_SVH
`define FESR_CFG_SVH
// ----------------------------------------
// Opcodes
// ----------------------------------------
`define FESR_OP_WREN 8'h06
`define FESR_OP_WRDI 8'h04
`define FESR_OP_WRSR 8'h01
`define FESR_OP_PROG 8'h02
`define FESR_OP_QPROG 8'h32
`define FESR_OP_SPROG 8'h42
`define FESR_OP_ER4K 8'h20
`define FESR_OP_ER32K 8'h52
`define FESR_OP_ER64K 8'hd8
`define FESR_OP_ERALL1 8'hc7
`define FESR_OP_ERALL2 8'h60
`define FESR_OP_SERASE 8'h44
`define FESR_OP_SUSP 8'h75
`define FESR_OP_RESUME 8'h7a
// ----------------------------------------
// Timing
// ----------------------------------------
`define FESR_CLK_NS 20
`define FESR_RESUME_NS 200
`define FESR_RESUME_CYC (`FESR_RESUME_NS / `FESR_CLK_NS)
`define FESR_ER4K_CYC 32'd2500000
`define FESR_ER32K_CYC 32'd7500000
`define FESR_ER64K_CYC 32'd10000000
`define FESR_ERALL_CYC 32'd100000000
`define FESR_PROG_CYC 32'd25000
`define FESR_SUS_CYC 32'd1000
`endif

//--- include/fesr_pkg.sv
package fesr_pkg;
   typedef enum logic [3:0] {
      FESR_OP_NONE = 4'h1,
      FESR_OP_ERASE = 4'h2,
      FESR_OP_ERASEALL = 4'h4,
      FESR_OP_PROGRAM = 4'h8
   } fesr_kind_t;
   typedef enum logic [3:0] {
      FESR_IDLE = 4'h1,
      FESR_RUN = 4'h2,
      FESR_SUSPENDING = 4'h4,
      FESR_SUSPENDED = 4'h8
   } fesr_state_t;
endpackage : fesr_pkg

//--- design/fesr_shift_in.sv
`timescale 1ns/100ps
`default_nettype none
`include "fesr_cfg.svh"
module fesr_shift_in (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic serClk,
   input wire logic selectN,
   input wire logic serialIn,
   output logic [7:0] frameByte,
   output logic byteDone,
   output logic frameEnd,
   output logic frameAligned,
   output logic [5:0] frameBytes
);
   // ----------------------------------------
   // Synchronisers
   // ----------------------------------------
   logic [1:0] clkSync_q, selSync_q, dinSync_q;
   logic clkOld_q;
   logic selOld_q;
   logic [7:0] shift_q, shift_d;
   logic [2:0] bitCnt_q, bitCnt_d;
   logic [5:0] bytes_q, bytes_d;
   logic rise;
   logic [7:0] byte_q, byte_d;
   logic done_q, done_d;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         clkSync_q <= 2'h0;
         selSync_q <= 2'h3;
         dinSync_q <= 2'h0;
         clkOld_q <= 1'b0;
         selOld_q <= 1'b1;
         shift_q <= 8'h00;
         bitCnt_q <= 3'h0;
         bytes_q <= 6'h00;
         byte_q <= 8'h00;
         done_q <= 1'b0;
      end else begin
         clkSync_q <= {clkSync_q[0], serClk};
         selSync_q <= {selSync_q[0], selectN};
         dinSync_q <= {dinSync_q[0], serialIn};
         clkOld_q <= clkSync_q[1];
         selOld_q <= selSync_q[1];
         shift_q <= shift_d;
         bitCnt_q <= bitCnt_d;
         bytes_q <= bytes_d;
         byte_q <= byte_d;
         done_q <= done_d;
      end
   end
   // RULE22: rising edge sample
   assign rise = clkSync_q[1] & ~clkOld_q;
   always_comb begin
      shift_d = shift_q;
      bitCnt_d = bitCnt_q;
      bytes_d = bytes_q;
      byte_d = byte_q;
      done_d = 1'b0;
      if (selSync_q[1]) begin
         bitCnt_d = 3'h0;
         if (!selOld_q) begin
            bytes_d = bytes_q;
         end else begin
            bytes_d = 6'h00;
         end
      end else if (rise) begin
         shift_d = {shift_q[6:0], dinSync_q[1]};
         bitCnt_d = bitCnt_q + 3'h1;
         if (bitCnt_q == 3'h7) begin
            byte_d = {shift_q[6:0], dinSync_q[1]};
            done_d = 1'b1;
            if (bytes_q != 6'h3f) begin
               bytes_d = bytes_q + 6'h01;
            end
         end
      end
   end
   assign frameByte = byte_q;
   assign byteDone = done_q;
   assign frameEnd = selSync_q[1] & ~selOld_q;
   // RULE5: byte boundary check
   assign frameAligned = (bitCnt_q == 3'h0);
   assign frameBytes = bytes_q;
endmodule : fesr_shift_in
`default_nettype wire

//--- design/fesr_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
`include "fesr_cfg.svh"
// Function
// RULE1: Opcode 20h plus address erases the addressed 4 KB sector to ones.
// RULE2: Erases accepted only with write latch set; host writes enable first.
// RULE3: Opcode D8h erases a 64 KB block, 52h a 32 KB half block.
// RULE4: Opcodes C7h and 60h erase whole array, no address bytes.
// RULE5: Select must rise on a byte boundary, else command discarded.
// RULE6: Busy held high during self-timed erase, status stays readable.
// RULE7: Write latch cleared when an erase cycle completes.
// RULE8: Protected region erase refused; chip erase refused if anything protected.
// RULE9: Suspend acted on only when not suspended, busy, and suspendable op runs.
// RULE10: Suspend ignored during chip erase.
// RULE11: During erase suspend, status write and all erases rejected.
// RULE12: During program suspend, status write and programs rejected.
// RULE13: Accepted suspend sets suspend flag at once, busy drops within latency.
// RULE14: Suspended device allows other-region work per suspended kind.
// RULE15: Program or erase aimed at suspended sector ignored.
// RULE16: Resume clears suspend flag now, raises busy within 200 ns, finishes.
// RULE17: Resume ignored unless suspended and not busy.
// RULE18: Host waits suspend latency after resume before suspending again.
// RULE19: Power loss while suspended leaves suspend flag at zero.
// RULE20: Write-disable opcode clears the write latch.
// RULE21: Write-enable opcode sets the write latch.
// RULE22: Opcode and address bits sampled on serial clock rising edge.
// RULE23: Erase and suspend durations are cycle-count parameters.
module fesr_sequencer #(
   parameter logic [31:0] ER4K_CYC = `FESR_ER4K_CYC,
   parameter logic [31:0] ER32K_CYC = `FESR_ER32K_CYC,
   parameter logic [31:0] ER64K_CYC = `FESR_ER64K_CYC,
   parameter logic [31:0] ERALL_CYC = `FESR_ERALL_CYC,
   parameter logic [31:0] PROG_CYC = `FESR_PROG_CYC,
   parameter logic [31:0] SUS_CYC = `FESR_SUS_CYC
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic serClk,
   input wire logic selectN,
   input wire logic serialIn,
   input wire logic [23:0] protectLow,
   input wire logic [23:0] protectHigh,
   input wire logic protectAny,
   output logic busyFlag,
   output logic write_latch_flag,
   output logic suspend_flag,
   output logic eraseStart,
   output logic [23:0] eraseBase,
   output logic [23:0] eraseSize,
   output logic eraseDone
);
   // ----------------------------------------
   // Frame capture
   // ----------------------------------------
   logic [7:0] frameByte;
   logic byteDone, frameEnd, frameAligned;
   logic [5:0] frameBytes;
   // RULE22: rising edge capture
   fesr_shift_in u_shift (
      .clk_sys(clk_sys),
      .rst(rst),
      .serClk(serClk),
      .selectN(selectN),
      .serialIn(serialIn),
      .frameByte(frameByte),
      .byteDone(byteDone),
      .frameEnd(frameEnd),
      .frameAligned(frameAligned),
      .frameBytes(frameBytes)
   );
   // ----------------------------------------
   // Opcode and address capture
   // ----------------------------------------
   logic [7:0] op_q, op_d;
   logic [23:0] addr_q, addr_d;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         op_q <= 8'h00;
         addr_q <= 24'h000000;
      end else begin
         op_q <= op_d;
         addr_q <= addr_d;
      end
   end
   always_comb begin
      op_d = op_q;
      addr_d = addr_q;
      if (byteDone) begin
         if (frameBytes == 6'h01) begin
            op_d = frameByte;
         end else if (frameBytes <= 6'h04) begin
            addr_d = {addr_q[15:0], frameByte};
         end
      end
   end
   // ----------------------------------------
   // Decode helpers
   // ----------------------------------------
   function automatic logic [23:0] fesr_size(input logic [7:0] op);
      case (op)
         `FESR_OP_ER4K: fesr_size = 24'h001000;
         `FESR_OP_ER32K: fesr_size = 24'h008000;
         `FESR_OP_ER64K: fesr_size = 24'h010000;
         `FESR_OP_PROG, `FESR_OP_QPROG: fesr_size = 24'h000100;
         default: fesr_size = 24'h100000;
      endcase
   endfunction : fesr_size
   function automatic logic [31:0] fesr_time(input logic [7:0] op);
      case (op)
         `FESR_OP_ER4K: fesr_time = ER4K_CYC;
         `FESR_OP_ER32K: fesr_time = ER32K_CYC;
         `FESR_OP_ER64K: fesr_time = ER64K_CYC;
         `FESR_OP_PROG, `FESR_OP_QPROG: fesr_time = PROG_CYC;
         default: fesr_time = ERALL_CYC;
      endcase
   endfunction : fesr_time
   // ----------------------------------------
   // Command qualifiers
   // ----------------------------------------
   logic isErase, isAll, isProg, isSized, isFrameOk, hitsProt, hitsSusp;
   logic [23:0] base;
   assign isAll = (op_q == `FESR_OP_ERALL1) || (op_q == `FESR_OP_ERALL2);
   assign isSized = (op_q == `FESR_OP_ER4K) || (op_q == `FESR_OP_ER32K) ||
      (op_q == `FESR_OP_ER64K);
   assign isErase = isAll || isSized;
   assign isProg = (op_q == `FESR_OP_PROG) || (op_q == `FESR_OP_QPROG);
   assign base = addr_q & ~(fesr_size(op_q) - 24'h000001);
   // RULE5: exact length check
   assign isFrameOk = frameAligned &&
      (isAll ? (frameBytes == 6'h01) : (frameBytes == 6'h04));
   // RULE8: protection overlap
   assign hitsProt = isAll ? protectAny :
      ((base <= protectHigh) && ((base + fesr_size(op_q) - 24'h000001) >= protectLow));
   // ----------------------------------------
   // Operation state machine
   // ----------------------------------------
   fesr_pkg::fesr_state_t st_q, st_d;
   fesr_pkg::fesr_kind_t kind_q, kind_d;
   logic [31:0] cnt_q, cnt_d;
   logic [31:0] left_q, left_d;
   logic [23:0] opBase_q, opBase_d, opSize_q, opSize_d;
   logic wel_q, wel_d, sus_q, sus_d, busy_q, busy_d;
   logic start_q, start_d, done_q, done_d;
   // RULE15: suspended sector guard
   assign hitsSusp = sus_q && ((addr_q & 24'hfff000) == (opBase_q & 24'hfff000));
   // ----------------------------------------
   // Operation registers
   // ----------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_q <= fesr_pkg::FESR_IDLE;
         kind_q <= fesr_pkg::FESR_OP_NONE;
         cnt_q <= 32'h00000000;
         left_q <= 32'h00000000;
         opBase_q <= 24'h000000;
         opSize_q <= 24'h000000;
         wel_q <= 1'b0;
         // RULE19: suspend cleared at power-up
         sus_q <= 1'b0;
         busy_q <= 1'b0;
         start_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         st_q <= st_d;
         kind_q <= kind_d;
         cnt_q <= cnt_d;
         left_q <= left_d;
         opBase_q <= opBase_d;
         opSize_q <= opSize_d;
         wel_q <= wel_d;
         sus_q <= sus_d;
         busy_q <= busy_d;
         start_q <= start_d;
         done_q <= done_d;
      end
   end
   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   always_comb begin
      st_d = st_q;
      kind_d = kind_q;
      cnt_d = cnt_q;
      left_d = left_q;
      opBase_d = opBase_q;
      opSize_d = opSize_q;
      wel_d = wel_q;
      sus_d = sus_q;
      busy_d = busy_q;
      start_d = 1'b0;
      done_d = 1'b0;
      unique case (st_q)
         fesr_pkg::FESR_IDLE: begin
            // RULE2: latch required
            // RULE14: other-region erase
            if (frameEnd && isErase && isFrameOk && wel_q && !hitsProt) begin
               // RULE11: erase suspend blocks erases
               // RULE10: chip erase only when not suspended
               if (!sus_q || (kind_q == fesr_pkg::FESR_OP_PROGRAM && !isAll && !hitsSusp)) begin
                  // RULE1: sector erase start
                  // RULE3: block erase start
                  // RULE4: chip erase start
                  // RULE6: busy raised
                  st_d = fesr_pkg::FESR_RUN;
                  busy_d = 1'b1;
                  start_d = 1'b1;
                  cnt_d = fesr_time(op_q);
                  opBase_d = isAll ? 24'h000000 : base;
                  opSize_d = fesr_size(op_q);
                  kind_d = isAll ? fesr_pkg::FESR_OP_ERASEALL : fesr_pkg::FESR_OP_ERASE;
                  left_d = cnt_q;
               end
            end
            // RULE12: program suspend blocks programs
            // RULE14: program during erase suspend
            else if (frameEnd && isProg && frameAligned && frameBytes > 6'h04 && wel_q &&
                  !hitsProt &&
                  (!sus_q || (kind_q == fesr_pkg::FESR_OP_ERASE && !hitsSusp))) begin
               st_d = fesr_pkg::FESR_RUN;
               busy_d = 1'b1;
               cnt_d = PROG_CYC;
               opBase_d = addr_q;
               opSize_d = 24'h000100;
               kind_d = fesr_pkg::FESR_OP_PROGRAM;
            end
            // RULE16: resume accepted
            // RULE17: resume conditions
            else if (frameEnd && frameAligned && frameBytes == 6'h01 &&
                  op_q == `FESR_OP_RESUME && sus_q && !busy_q) begin
               sus_d = 1'b0;
               st_d = fesr_pkg::FESR_SUSPENDED;
               cnt_d = 32'(`FESR_RESUME_CYC);
            end
         end
         fesr_pkg::FESR_RUN: begin
            // RULE23: timer countdown
            if (cnt_q <= 32'h00000001) begin
               st_d = fesr_pkg::FESR_IDLE;
               busy_d = 1'b0;
               // RULE7: latch cleared
               wel_d = 1'b0;
               done_d = (kind_q != fesr_pkg::FESR_OP_PROGRAM);
               kind_d = fesr_pkg::FESR_OP_NONE;
               cnt_d = 32'h00000000;
            end else begin
               cnt_d = cnt_q - 32'h00000001;
            end
            // RULE9: suspend acceptance
            // RULE10: chip erase not suspendable
            if (frameEnd && frameAligned && frameBytes == 6'h01 && op_q == `FESR_OP_SUSP &&
                  !sus_q && busy_q && kind_q != fesr_pkg::FESR_OP_ERASEALL &&
                  cnt_q > 32'h00000001) begin
               // RULE13: suspend flag at once
               sus_d = 1'b1;
               left_d = cnt_q;
               cnt_d = SUS_CYC;
               st_d = fesr_pkg::FESR_SUSPENDING;
            end
         end
         fesr_pkg::FESR_SUSPENDING: begin
            // RULE13: busy drops within latency
            if (cnt_q <= 32'h00000001) begin
               busy_d = 1'b0;
               st_d = fesr_pkg::FESR_IDLE;
               cnt_d = left_q;
            end else begin
               cnt_d = cnt_q - 32'h00000001;
            end
         end
         fesr_pkg::FESR_SUSPENDED: begin
            // RULE16: busy back within 200 ns
            if (cnt_q <= 32'h00000001) begin
               busy_d = 1'b1;
               st_d = fesr_pkg::FESR_RUN;
               cnt_d = left_q;
            end else begin
               cnt_d = cnt_q - 32'h00000001;
            end
         end
         default: begin
            st_d = fesr_pkg::FESR_IDLE;
         end
      endcase
      // Latch commands last so a write enable wins over a completion clear
      if (frameEnd && frameAligned) begin
         // RULE21: write enable
         if (op_q == `FESR_OP_WREN && frameBytes == 6'h01) begin
            wel_d = 1'b1;
         end
         // RULE20: write disable
         if (op_q == `FESR_OP_WRDI && frameBytes == 6'h01) begin
            wel_d = 1'b0;
         end
      end
   end
   // ----------------------------------------
   // Status outputs
   // ----------------------------------------
   assign busyFlag = busy_q;
   assign write_latch_flag = wel_q;
   assign suspend_flag = sus_q;
   assign eraseStart = start_q;
   assign eraseBase = opBase_q;
   assign eraseSize = opSize_q;
   assign eraseDone = done_q;
endmodule : fesr_sequencer
`default_nettype wire

//--- sim/fesr_checker.sv
`timescale 1ns/100ps
`default_nettype none
module fesr_checker #(
   parameter logic [31:0] SUS_CYC = 32'd20
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic busyFlag,
   input wire logic write_latch_flag,
   input wire logic suspend_flag,
   input wire logic eraseStart,
   input wire logic [23:0] eraseBase,
   input wire logic [23:0] eraseSize,
   input wire logic eraseDone
);
   // ----------------------------------------
   // Suspend latency counter
   // ----------------------------------------
   logic [31:0] susCnt_q;
   logic [31:0] susCnt_d;
   logic susOld_q;
   // Counts only from the suspend edge, not later busy spells while suspended
   always_comb begin
      susCnt_d = (suspend_flag && busyFlag && (!susOld_q || susCnt_q != 32'h0)) ?
         susCnt_q + 32'h1 : 32'h0;
   end
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         susCnt_q <= 32'h0;
         susOld_q <= 1'b0;
      end else begin
         susCnt_q <= susCnt_d;
         susOld_q <= suspend_flag;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   start_busy_a: assert property (eraseStart |=> busyFlag)
      else $error("busy not raised after start");
   busy_end_a: assert property ($fell(busyFlag) |-> suspend_flag || eraseDone || $past(eraseDone))
      else $error("busy dropped without completion");
   done_latch_a: assert property (eraseDone |-> ##[0:1] (!write_latch_flag && !busyFlag))
      else $error("latch or busy not cleared at completion");
   start_latch_a: assert property (eraseStart |-> write_latch_flag)
      else $error("erase started without latch");
   sector_align_a: assert property (eraseStart && eraseSize == 24'h001000 |-> eraseBase[11:0] == 12'h000)
      else $error("sector base unaligned");
   suspend_gate_a: assert property ($rose(suspend_flag) |-> $past(busyFlag))
      else $error("suspend taken while idle");
   sus_latency_a: assert property (susCnt_q <= SUS_CYC + 32'h1)
      else $error("busy not dropped within suspend latency");
   resume_busy_a: assert property ($fell(suspend_flag) |-> ##[1:10] busyFlag)
      else $error("busy not back within 200 ns");
   resume_gate_a: assert property ($fell(suspend_flag) |-> !$past(busyFlag))
      else $error("resume taken while busy");
   reset_clear_a: assert property (@(posedge clk_sys) disable iff (1'b0) rst |-> !suspend_flag)
      else $error("suspend flag set in reset");
endmodule : fesr_checker
bind fesr_sequencer fesr_checker #(.SUS_CYC(SUS_CYC)) u_chk (.clk_sys(clk_sys), .rst(rst),
   .busyFlag(busyFlag), .write_latch_flag(write_latch_flag), .suspend_flag(suspend_flag),
   .eraseStart(eraseStart), .eraseBase(eraseBase), .eraseSize(eraseSize),
   .eraseDone(eraseDone));
`default_nettype wire

//--- sim/fesr_host.sv
`timescale 1ns/100ps
`default_nettype none
module fesr_host (
   input wire logic clk_sys,
   output logic serClk,
   output logic selectN,
   output logic serialIn
);
   // ----------------------------------------
   // Serial frame driver, 160 ns bit period
   // ----------------------------------------
   initial begin
      serClk = 1'b0;
      selectN = 1'b1;
      serialIn = 1'b1;
   end
   task automatic send(input logic [39:0] d, input int nbits);
      int i;
      @(posedge clk_sys);
      selectN <= 1'b0;
      for (i = 0; i < nbits; i++) begin
         serialIn <= d[39 - i];
         repeat (4) @(posedge clk_sys);
         serClk <= 1'b1;
         repeat (4) @(posedge clk_sys);
         serClk <= 1'b0;
      end
      repeat (4) @(posedge clk_sys);
      selectN <= 1'b1;
      serialIn <= ~serialIn;
      repeat (8) @(posedge clk_sys);
   endtask : send
endmodule : fesr_host
`default_nettype wire

//--- sim/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
   // ----------------------------------------
   // Design, partner and model state
   // ----------------------------------------
   localparam logic [31:0] C4K = 32'd200;
   localparam logic [31:0] C32K = 32'd300;
   localparam logic [31:0] C64K = 32'd400;
   localparam logic [31:0] CALL = 32'd500;
   localparam logic [31:0] CSUS = 32'd20;
   logic clk_sys, rst, serClk, selectN, serialIn, protectAny, busyFlag;
   logic write_latch_flag, suspend_flag, eraseStart, eraseDone;
   logic [23:0] protectLow, protectHigh, eraseBase, eraseSize, qBase[$], qSize[$];
   logic [31:0] a;
   int miscompares = 0, n_checks = 0, cycles = 0, startCyc = 0, doneCyc = 0;
   int seed = 32'h75868777, mLatch = 0, mBusy = 0, mSus = 0, i;
   logic [7:0] ops[5] = '{8'h20, 8'h52, 8'hd8, 8'hc7, 8'h60};
   logic [23:0] szs[5] = '{24'h001000, 24'h008000, 24'h010000, 24'h0, 24'h0};
   logic [31:0] cycs[5] = '{C4K, C32K, C64K, CALL, CALL};
   fesr_sequencer #(.ER4K_CYC(C4K), .ER32K_CYC(C32K), .ER64K_CYC(C64K), .ERALL_CYC(CALL),
      .PROG_CYC(32'd250), .SUS_CYC(CSUS)) u_dut (.clk_sys(clk_sys), .rst(rst),
      .serClk(serClk), .selectN(selectN), .serialIn(serialIn), .protectLow(protectLow),
      .protectHigh(protectHigh), .protectAny(protectAny), .busyFlag(busyFlag),
      .write_latch_flag(write_latch_flag), .suspend_flag(suspend_flag),
      .eraseStart(eraseStart), .eraseBase(eraseBase), .eraseSize(eraseSize),
      .eraseDone(eraseDone));
   fesr_host u_host (.clk_sys(clk_sys), .serClk(serClk), .selectN(selectN),
      .serialIn(serialIn));
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : report_and_stop
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (eraseStart === 1'b1) begin
         qBase.push_back(eraseBase);
         qSize.push_back(eraseSize);
         startCyc <= cycles;
      end
      if (eraseDone === 1'b1) begin
         doneCyc <= cycles;
      end
      if (cycles == 40000) begin
         miscompares++;
         report_and_stop();
      end
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check
   task automatic flags();
      check({31'h0, write_latch_flag}, mLatch, "latch");
      check({31'h0, busyFlag}, mBusy, "busy");
      check({31'h0, suspend_flag}, mSus, "suspend");
   endtask : flags
   task automatic wren();
      u_host.send(40'h0600000000, 8);
      mLatch = 1;
   endtask : wren
   task automatic wait_idle(input int lim);
      for (int k = 0; k < lim && busyFlag !== 1'b0; k++) @(negedge clk_sys);
      repeat (2) @(negedge clk_sys);
   endtask : wait_idle
   task automatic erase(input logic [7:0] op, input logic [23:0] ad, input logic [23:0] sz,
      input int cyc);
      wren();
      u_host.send({op, ad, 8'h00}, (sz == 24'h0) ? 8 : 32);
      mBusy = 1;
      flags();
      check(qSize.size(), 1, "start");
      if (sz != 24'h0 && qSize.size() > 0) begin
         check({8'h0, qSize[0]}, {8'h0, sz}, "size");
         check({8'h0, qBase[0]}, {8'h0, ad & ~(sz - 24'h1)}, "base");
      end
      qSize.delete();
      qBase.delete();
      wait_idle(cyc + 40);
      check((doneCyc - startCyc >= cyc - 2) && (doneCyc - startCyc <= cyc + 2), 1, "time");
      mBusy = 0;
      mLatch = 0;
      flags();
   endtask : erase
   initial begin
      rst = 1'b1;
      protectLow = 24'hffffff;
      protectHigh = 24'h0;
      protectAny = 1'b0;
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (3) @(posedge clk_sys);
      flags();
      u_host.send(40'h2000100000, 32);
      check(qSize.size(), 0, "no latch");
      wren();
      flags();
      u_host.send(40'h0400000000, 8);
      mLatch = 0;
      flags();
      wren();
      u_host.send(40'h2000200000, 31);
      check(qSize.size(), 0, "unaligned");
      for (i = 0; i < 5; i++) begin
         a = $random(seed);
         erase(ops[i], a[23:0], szs[i], cycs[i]);
      end
      a = $random(seed);
      @(posedge clk_sys);
      protectLow <= {a[23:12], 12'h000};
      protectHigh <= {a[23:12], 12'hfff};
      protectAny <= 1'b1;
      wren();
      u_host.send({8'h20, a[23:0], 8'h00}, 32);
      u_host.send(40'hc700000000, 8);
      check(qSize.size(), 0, "protected");
      flags();
      @(posedge clk_sys);
      protectLow <= 24'hffffff;
      protectAny <= 1'b0;
      u_host.send(40'h7500000000, 8);
      flags();
      wren();
      u_host.send(40'h2001000000, 32);
      mBusy = 1;
      qSize.delete();
      u_host.send(40'h7500000000, 8);
      mSus = 1;
      flags();
      repeat (CSUS) @(negedge clk_sys);
      mBusy = 0;
      flags();
      u_host.send(40'h7500000000, 8);
      flags();
      u_host.send(40'h2002000000, 32);
      u_host.send(40'h2001000000, 32);
      check(qSize.size(), 0, "suspended erase");
      u_host.send(40'h0200800000, 40);
      mBusy = 1;
      flags();
      wait_idle(290);
      mBusy = 0;
      mLatch = 0;
      flags();
      u_host.send(40'h7a00000000, 8);
      check({31'h0, suspend_flag}, 0, "resume");
      repeat (10) @(negedge clk_sys);
      mSus = 0;
      mBusy = 1;
      flags();
      u_host.send(40'h7a00000000, 8);
      flags();
      wait_idle(C4K + 40);
      qSize.delete();
      mBusy = 0;
      mLatch = 0;
      flags();
      wren();
      u_host.send(40'hc700000000, 8);
      u_host.send(40'h7500000000, 8);
      mBusy = 1;
      flags();
      wait_idle(CALL + 40);
      qSize.delete();
      wren();
      u_host.send(40'h0200400000, 40);
      u_host.send(40'h7500000000, 8);
      repeat (CSUS) @(negedge clk_sys);
      mBusy = 0;
      mSus = 1;
      flags();
      u_host.send(40'h0200800000, 40);
      u_host.send(40'h2000400000, 32);
      check(qSize.size(), 0, "program suspended");
      u_host.send(40'h2000800000, 32);
      check(qSize.size(), 1, "erase elsewhere");
      wait_idle(C4K + 40);
      mLatch = 0;
      flags();
      u_host.send(40'h7a00000000, 8);
      repeat (10) @(negedge clk_sys);
      mSus = 0;
      mBusy = 1;
      flags();
      wait_idle(300);
      mBusy = 0;
      flags();
      wren();
      u_host.send(40'h2003000000, 32);
      u_host.send(40'h7500000000, 8);
      repeat (CSUS) @(posedge clk_sys);
      rst <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (3) @(posedge clk_sys);
      mBusy = 0;
      mLatch = 0;
      mSus = 0;
      flags();
      report_and_stop();
   end
endmodule : testbench
`default_nettype wire
